// ### hdl/cpusm_defines.svh
/*
  cpusm_defines.svh: constants for the processing-state controller.
  Assumes inclusion by bare name from the hdl/ directory.
*/
`ifndef CPUSM_DEFINES_SVH
`define CPUSM_DEFINES_SVH

// reset exception vector location
`define CPUSM_RST_VEC_ADDR   24'h000000
// count loaded on a watchdog overflow; the reset state lasts one cycle more than this
`define CPUSM_WDT_RST_CYC    4'h4
// reset value of the pin synchronisers {standby_in_n_n, res_n, md2, md1, md0}
`define CPUSM_PIN_SYNC_RST   5'h00
// last byte address of the 24-bit space, plus one
`define CPUSM_ADDR_END       25'h1000000
// operating mode numbers, equal to the pin pattern that selects them
`define CPUSM_MODE_1         3'h1
`define CPUSM_MODE_2         3'h2
`define CPUSM_MODE_3         3'h3
`define CPUSM_MODE_6         3'h6
`define CPUSM_MODE_7         3'h7
`define CPUSM_MODE_NONE      3'h0

`endif

// ### hdl/cpusm_pkg.sv
/*
  cpusm_pkg: types shared by the processing-state controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cpusm_pkg;

  // processing states, one-hot
  typedef enum logic [5:0] {
    CPUSM_ST_RESET  = 6'h01,
    CPUSM_ST_EXCEPT = 6'h02,
    CPUSM_ST_EXEC   = 6'h04,
    CPUSM_ST_BUSREL = 6'h08,
    CPUSM_ST_STOP   = 6'h10,
    CPUSM_ST_HWSTBY = 6'h20
  } cpusm_state_e;

  // memory sequencer states, one-hot
  typedef enum logic [2:0] {
    CPUSM_DP_IDLE  = 3'h1,
    CPUSM_DP_READ  = 3'h2,
    CPUSM_DP_WRITE = 3'h4
  } cpusm_dp_e;

  // memory operations run by the sequencer
  typedef enum logic [2:0] {
    CPUSM_OP_BIT_SET    = 3'h0,
    CPUSM_OP_BIT_CLEAR  = 3'h1,
    CPUSM_OP_BIT_INVERT = 3'h2,
    CPUSM_OP_BIT_STORE  = 3'h3,
    CPUSM_OP_BIT_STINV  = 3'h4,
    CPUSM_OP_BLOCK_MOVE = 3'h5
  } cpusm_op_e;

endpackage : cpusm_pkg

// ### hdl/cpusm_mode_if.sv
/*
  cpusm_mode_if: carries mode pins in and the decoded mode out between
  the controller and its mode decoder. Assumes one shared clock.
*/
`timescale 1ns/10ps
interface cpusm_mode_if;
  logic [2:0] pins;        // synchronised mode pins {hi, mid, lo}
  logic       sample_en;   // high while in reset: capture the mode
  logic       status_rd;   // pulse: latch pins into status
  logic [2:0] mode_num;    // decoded mode, 0 when invalid
  logic       adv_addr;    // advanced addressing
  logic       rom_en;      // on-chip rom enabled
  logic       emul;        // emulation mode
  logic       ext_bus;     // external extended bus forced
  logic       invalid;     // unsupported pin pattern
  logic [2:0] pin_status;  // latched pin levels

  modport dec (input pins, sample_en, status_rd,
               output mode_num, adv_addr, rom_en, emul, ext_bus,
               invalid, pin_status);
  modport ctl (output pins, sample_en, status_rd,
               input mode_num, adv_addr, rom_en, emul, ext_bus,
               invalid, pin_status);
endinterface : cpusm_mode_if

// ### hdl/cpusm_mode_dec.sv
/*
  cpusm_mode_dec: captures the mode pins during reset and decodes the
  operating mode; keeps the pin status latch.
  Assumes pins arrive already synchronised to clock.
*/
`timescale 1ns/10ps
`include "cpusm_defines.svh"
module cpusm_mode_dec
  import cpusm_pkg::*;
#(
  parameter bit HAS_HI_PIN = 1'b1
) (
  input wire logic  clock,      // system clock
  input wire logic  sys_rst,    // async reset, active high
  cpusm_mode_if.dec mif         // pins in, decoded mode out
);

  logic [2:0] mode_ff;
  logic [2:0] status_ff;
  logic [2:0] pins_eff;
  logic       valid;

  function automatic logic mode_ok(input logic [2:0] m);
    mode_ok = (m == `CPUSM_MODE_1) || (m == `CPUSM_MODE_2) ||
              (m == `CPUSM_MODE_3) || (m == `CPUSM_MODE_6) ||
              (m == `CPUSM_MODE_7);
  endfunction : mode_ok

  assign pins_eff = {HAS_HI_PIN ? mif.pins[2] : 1'b0, mif.pins[1:0]};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ff <= `CPUSM_MODE_NONE;
    end else if (mif.sample_en) begin
      mode_ff <= pins_eff;
    end
  end

  // status latch, follows pins in reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      status_ff <= `CPUSM_MODE_NONE;
    end else if (mif.sample_en || mif.status_rd) begin
      status_ff <= pins_eff;
    end
  end

  assign valid        = mode_ok(mode_ff);
  assign mif.invalid  = !valid;
  assign mif.mode_num = valid ? mode_ff : `CPUSM_MODE_NONE;
  assign mif.ext_bus  = valid && (mode_ff == `CPUSM_MODE_1);
  assign mif.adv_addr = valid && ((mode_ff == `CPUSM_MODE_1) ||
                                  (mode_ff == `CPUSM_MODE_2));
  assign mif.emul     = valid && mode_ff[2];
  assign mif.rom_en   = valid && (mode_ff != `CPUSM_MODE_1);
  assign mif.pin_status = status_ff;

  property p_mode1;
    @(posedge clock) disable iff (sys_rst)
    (mif.mode_num == `CPUSM_MODE_1) |->
      (!mif.rom_en && mif.ext_bus && mif.adv_addr && !mif.emul);
  endproperty
  a_mode1: assert property (p_mode1)
    else $error("mode 1 decode wrong");

  property p_mode_hold;
    @(posedge clock) disable iff (sys_rst)
    !mif.sample_en |=> $stable(mif.mode_num);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed outside reset");

  property p_mode_valid;
    @(posedge clock) disable iff (sys_rst)
    (mif.mode_num == `CPUSM_MODE_NONE) |-> !mif.rom_en && !mif.emul;
  endproperty
  a_mode_valid: assert property (p_mode_valid)
    else $error("invalid mode enabled features");

endmodule : cpusm_mode_dec

// ### hdl/cpusm_ctrl.sv
/*
  cpusm_ctrl: processing-state controller of a 16-bit cpu core, with a
  byte sequencer for bit read-modify-write and block moves.
  Assumes reset/standby/mode pins are asynchronous; bus request, memory
  and watchdog signals come from logic on clock.
*/
// Function
// - reset pin low stops all, enters reset
// - interrupts masked in reset state
// - reset exception starts on pin release
// - watchdog overflow enters reset state too
// - exception handling entered from listed sources
// - fetch vector, branch, then execute
// - execute instructions in sequence
// - release bus, halt cpu while granted
// - sleep or standby stops the cpu
// - reset pin low wins except standby
// - standby pin low forces standby always
// - bit ops read byte, modify bit, write
// - block move copies count bytes
// - pins 001 select mode 1
// - pins 010, 011 select modes 2, 3
// - pins 110, 111 select emulation
// - modes 0, 4, 5 not offered
// - missing top mode pin reads zero
// - status bits latch pins on read
`timescale 1ns/10ps
`include "cpusm_defines.svh"
module cpusm_ctrl
  import cpusm_pkg::*;
#(
  parameter bit HAS_HI_PIN = 1'b1,  // package has the top mode pin
  parameter int CNT_W      = 16     // block move count width
) (
  input  wire logic        clock,            // 10 MHz system clock
  input  wire logic        sys_rst,          // async reset, active high
  input  wire logic        chip_reset_in_n,  // reset pin, low active
  input  wire logic        standby_in_n,     // standby pin, low active
  input  wire logic        mode_sel_pin_hi,  // mode pin 2
  input  wire logic        mode_sel_pin_mid, // mode pin 1
  input  wire logic        mode_sel_pin_lo,  // mode pin 0
  input  wire logic        wdt_ovf,          // watchdog overflow pulse
  input  wire logic        bus_req,          // other master wants bus
  output logic             bus_grant,        // bus released to master
  input  wire logic        exc_req,          // trace/irq/trap request
  input  wire logic [23:0] exc_vec_addr,     // vector slot of request
  output logic             exc_ack,          // request taken, pulse
  input  wire logic        sleep_exec,       // sleep instruction pulse
  output logic             vec_rd_req,       // vector read request
  output logic [23:0]      vec_rd_addr,      // vector slot address
  input  wire logic        vec_rd_ack,       // vector read done
  input  wire logic [23:0] vec_rd_data,      // fetched start address
  output logic             exec_step,        // instruction may issue
  input  wire logic        instr_done,       // instruction retired
  input  wire logic [2:0]  instr_len,        // its length in bytes
  output logic [23:0]      pc,               // program counter
  input  wire logic        op_start,         // memory op request
  output logic             op_ready,         // op may be started
  input  wire logic [2:0]  op_kind,          // cpusm_op_e code
  input  wire logic [23:0] op_addr,          // bit op byte / source
  input  wire logic [23:0] op_dst,           // block move destination
  input  wire logic [CNT_W-1:0] op_count,    // block move byte count
  input  wire logic [2:0]  op_bit,           // bit number
  input  wire logic        op_carry,         // carry for bit store
  output logic             op_done,          // op finished, pulse
  output logic             op_range_err,     // move refused, pulse
  output logic             mem_rd_req,       // byte read request
  output logic             mem_wr_req,       // byte write request
  output logic [23:0]      mem_addr,         // byte address
  output logic [7:0]       mem_wdata,        // write byte
  input  wire logic        mem_ack,          // access done
  input  wire logic [7:0]  mem_rdata,        // read byte
  input  wire logic        mode_status_rd,   // mode register read
  output logic [5:0]       cpu_state,        // one-hot state
  output logic             periph_rst,       // peripherals held reset
  output logic             irq_mask,         // all interrupts masked
  output logic [2:0]       mode_num,         // operating mode
  output logic             adv_addr,         // advanced addressing
  output logic             rom_en,           // on-chip rom enabled
  output logic             emul_mode,        // emulation mode
  output logic             ext_bus,          // external bus forced
  output logic             mode_invalid,     // unsupported mode pins
  output logic [2:0]       mode_pin_status   // latched pin levels
);

  generate
    if (CNT_W < 1 || CNT_W > 24) begin : g_bad_cnt
      $error("CNT_W must lie in 1..24");
    end
  endgenerate

  cpusm_state_e   state_ff, nxt_state;
  cpusm_dp_e      dp_ff, nxt_dp;
  logic [4:0]     pin_meta_ff, pin_sync_ff;
  logic [3:0]     wdt_cnt_ff;
  logic [23:0]    vec_addr_ff, pc_ff, src_ff, dst_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [7:0]     wdata_ff;
  cpusm_op_e      kind_ff;
  logic [2:0]     bit_ff;
  logic           carry_ff, done_ff, err_ff;

  wire rst_pin_n  = pin_sync_ff[3];
  wire standby_in_n_pin_n = pin_sync_ff[4];
  wire st_reset   = (state_ff == CPUSM_ST_RESET);
  wire st_except  = (state_ff == CPUSM_ST_EXCEPT);
  wire st_exec    = (state_ff == CPUSM_ST_EXEC);
  wire st_busrel  = (state_ff == CPUSM_ST_BUSREL);
  wire st_stop    = (state_ff == CPUSM_ST_STOP);
  wire st_hwstby  = (state_ff == CPUSM_ST_HWSTBY);
  wire dp_idle    = (dp_ff == CPUSM_DP_IDLE);
  wire is_move    = (kind_ff == CPUSM_OP_BLOCK_MOVE);
  wire move_req   = (op_kind == CPUSM_OP_BLOCK_MOVE);
  wire [24:0] move_end = {1'b0, op_dst} + 25'(op_count);
  wire op_take    = op_start && op_ready;
  wire exc_take   = exc_req && dp_idle && st_exec;

  function automatic logic [7:0] bit_modify(input cpusm_op_e k,
    input logic [7:0] d, input logic [2:0] b, input logic c);
    logic [7:0] m;
    m = 8'h01 << b;
    case (k)
      CPUSM_OP_BIT_SET:    bit_modify = d | m;
      CPUSM_OP_BIT_CLEAR:  bit_modify = d & ~m;
      CPUSM_OP_BIT_INVERT: bit_modify = d ^ m;
      CPUSM_OP_BIT_STORE:  bit_modify = c ? (d | m) : (d & ~m);
      CPUSM_OP_BIT_STINV:  bit_modify = c ? (d & ~m) : (d | m);
      default:             bit_modify = d;
    endcase
  endfunction : bit_modify

  // two-stage synchronisers for the asynchronous pins
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_ff <= `CPUSM_PIN_SYNC_RST;
      pin_sync_ff <= `CPUSM_PIN_SYNC_RST;
    end else begin
      pin_meta_ff <= {standby_in_n, chip_reset_in_n, mode_sel_pin_hi,
                      mode_sel_pin_mid, mode_sel_pin_lo};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // main state transitions; standby outranks reset, reset the rest
  always_comb begin
    nxt_state = state_ff;
    if (!standby_in_n_pin_n) begin
      nxt_state = CPUSM_ST_HWSTBY;
    end else if (st_hwstby) begin
      // leaving standby always goes through a full reset
      nxt_state = CPUSM_ST_RESET;
    end else if (!rst_pin_n || wdt_ovf) begin
      nxt_state = CPUSM_ST_RESET;
    end else begin
      case (state_ff)
        CPUSM_ST_RESET: begin
          if (wdt_cnt_ff == 4'h0) nxt_state = CPUSM_ST_EXCEPT;
        end
        CPUSM_ST_EXCEPT: begin
          if (vec_rd_ack) nxt_state = CPUSM_ST_EXEC;
        end
        // leave execution at an op boundary
        CPUSM_ST_EXEC: begin
          if (exc_take) nxt_state = CPUSM_ST_EXCEPT;
          else if (bus_req && dp_idle) nxt_state = CPUSM_ST_BUSREL;
          else if (sleep_exec && dp_idle) nxt_state = CPUSM_ST_STOP;
        end
        CPUSM_ST_BUSREL: begin
          if (!bus_req) nxt_state = CPUSM_ST_EXEC;
        end
        // an interrupt wakes the cpu through exception handling
        CPUSM_ST_STOP: begin
          if (exc_req) nxt_state = CPUSM_ST_EXCEPT;
        end
        default: nxt_state = CPUSM_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) state_ff <= CPUSM_ST_RESET;
    else         state_ff <= nxt_state;
  end

  // watchdog reset stretch, counted down only in reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_cnt_ff <= 4'h0;
    end else if (wdt_ovf && standby_in_n_pin_n && !st_hwstby) begin
      wdt_cnt_ff <= `CPUSM_WDT_RST_CYC;
    end else if (st_reset && wdt_cnt_ff != 4'h0) begin
      wdt_cnt_ff <= wdt_cnt_ff - 4'h1;
    end
  end

  // vector slot chosen on entry to exception handling
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      vec_addr_ff <= `CPUSM_RST_VEC_ADDR;
    end else if (st_reset) begin
      vec_addr_ff <= `CPUSM_RST_VEC_ADDR;
    end else if (nxt_state == CPUSM_ST_EXCEPT && !st_except) begin
      vec_addr_ff <= exc_vec_addr;
    end
  end

  // branch to vector, then step through instructions
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pc_ff <= 24'h000000;
    end else if (st_except && vec_rd_ack) begin
      pc_ff <= vec_rd_data;
    end else if (exec_step && instr_done) begin
      pc_ff <= pc_ff + 24'(instr_len);
    end
  end

  // sequencer next state: read byte, then write byte
  always_comb begin
    nxt_dp = dp_ff;
    case (dp_ff)
      CPUSM_DP_IDLE: begin
        if (op_take && !(move_req &&
            (op_count == '0 || move_end > `CPUSM_ADDR_END))) begin
          nxt_dp = CPUSM_DP_READ;
        end
      end
      CPUSM_DP_READ: begin
        if (mem_ack) nxt_dp = CPUSM_DP_WRITE;
      end
      CPUSM_DP_WRITE: begin
        if (mem_ack) begin
          if (is_move && cnt_ff != CNT_W'(1)) nxt_dp = CPUSM_DP_READ;
          else nxt_dp = CPUSM_DP_IDLE;
        end
      end
      default: nxt_dp = CPUSM_DP_IDLE;
    endcase
    // reset or standby aborts any transfer in flight
    if (st_reset || st_hwstby) nxt_dp = CPUSM_DP_IDLE;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) dp_ff <= CPUSM_DP_IDLE;
    else         dp_ff <= nxt_dp;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      kind_ff  <= CPUSM_OP_BIT_SET;
      bit_ff   <= 3'h0;
      carry_ff <= 1'b0;
      src_ff   <= 24'h000000;
      dst_ff   <= 24'h000000;
      cnt_ff   <= '0;
      wdata_ff <= 8'h00;
    end else if (op_take) begin
      kind_ff  <= cpusm_op_e'(op_kind);
      bit_ff   <= op_bit;
      carry_ff <= op_carry;
      src_ff   <= op_addr;
      dst_ff   <= move_req ? op_dst : op_addr;
      cnt_ff   <= op_count;
    end else if (mem_ack && dp_ff == CPUSM_DP_READ) begin
      wdata_ff <= is_move ? mem_rdata :
                  bit_modify(kind_ff, mem_rdata, bit_ff, carry_ff);
    end else if (mem_ack && dp_ff == CPUSM_DP_WRITE && is_move) begin
      src_ff <= src_ff + 24'h000001;
      dst_ff <= dst_ff + 24'h000001;
      cnt_ff <= cnt_ff - CNT_W'(1);
    end
  end

  // completion pulses; a move whose destination runs past the 24-bit end is refused
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      done_ff <= 1'b0;
      err_ff  <= 1'b0;
    end else begin
      done_ff <= (op_take && move_req && op_count == '0) ||
                 (op_take && move_req && move_end > `CPUSM_ADDR_END) ||
                 (dp_ff == CPUSM_DP_WRITE && mem_ack &&
                  nxt_dp == CPUSM_DP_IDLE && !st_reset && !st_hwstby);
      err_ff  <= op_take && move_req && move_end > `CPUSM_ADDR_END;
    end
  end

  // mode decoder hookup
  cpusm_mode_if mif ();
  assign mif.pins      = pin_sync_ff[2:0];
  // mode follows pins only while in reset
  assign mif.sample_en = st_reset;
  assign mif.status_rd = mode_status_rd;

  cpusm_mode_dec #(
    .HAS_HI_PIN (HAS_HI_PIN)
  ) u_mode_dec (
    .clock   (clock),
    .sys_rst (sys_rst),
    .mif     (mif)
  );

  // outputs
  assign cpu_state       = state_ff;
  // peripherals held while in reset or standby
  assign periph_rst      = st_reset || st_hwstby;
  assign irq_mask        = st_reset || st_hwstby;
  assign bus_grant       = st_busrel;
  assign exc_ack         = (exc_take || (st_stop && exc_req)) &&
                           rst_pin_n && standby_in_n_pin_n && !wdt_ovf;
  assign vec_rd_req      = st_except;
  assign vec_rd_addr     = vec_addr_ff;
  // one instruction at a time, only when sequencer is idle
  assign exec_step       = st_exec && dp_idle && !exc_req;
  assign pc              = pc_ff;
  assign op_ready        = st_exec && dp_idle && !exc_req && !bus_req;
  assign op_done         = done_ff;
  assign op_range_err    = err_ff;
  assign mem_rd_req      = (dp_ff == CPUSM_DP_READ);
  assign mem_wr_req      = (dp_ff == CPUSM_DP_WRITE);
  assign mem_addr        = mem_wr_req ? dst_ff : src_ff;
  assign mem_wdata       = wdata_ff;
  assign mode_num        = mif.mode_num;
  assign adv_addr        = mif.adv_addr;
  assign rom_en          = mif.rom_en;
  assign emul_mode       = mif.emul;
  assign ext_bus         = mif.ext_bus;
  assign mode_invalid    = mif.invalid;
  assign mode_pin_status = mif.pin_status;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_rst_pin;
    (!rst_pin_n && standby_in_n_pin_n && !st_hwstby) |=> st_reset;
  endproperty
  a_rst_pin: assert property (p_rst_pin)
    else $error("reset pin did not force reset state");

  property p_mask;
    st_reset |-> irq_mask && periph_rst && !exec_step;
  endproperty
  a_mask: assert property (p_mask)
    else $error("interrupts not masked in reset");

  property p_rst_exit;
    (st_reset && rst_pin_n && standby_in_n_pin_n && !wdt_ovf &&
     wdt_cnt_ff == 4'h0) |=> st_except && vec_rd_addr == 24'h000000;
  endproperty
  a_rst_exit: assert property (p_rst_exit)
    else $error("reset exception not started on release");

  property p_wdt;
    (wdt_ovf && standby_in_n_pin_n && !st_hwstby) |=> st_reset [*4];
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog reset not held four cycles");

  sequence s_vec_done;
    st_except && vec_rd_ack && rst_pin_n && standby_in_n_pin_n && !wdt_ovf;
  endsequence
  property p_branch;
    s_vec_done |=> st_exec && pc == $past(vec_rd_data);
  endproperty
  a_branch: assert property (p_branch)
    else $error("no branch to fetched vector");

  property p_bus;
    bus_grant |-> !exec_step && !mem_rd_req && !mem_wr_req && $past(bus_req);
  endproperty
  a_bus: assert property (p_bus)
    else $error("cpu active while bus released");

  property p_sleep;
    (st_exec && sleep_exec && dp_idle && !exc_req && !bus_req &&
     rst_pin_n && standby_in_n_pin_n && !wdt_ovf) |=> st_stop;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep did not stop the cpu");

  property p_standby_in_n;
    !standby_in_n_pin_n |=> st_hwstby;
  endproperty
  a_standby_in_n: assert property (p_standby_in_n)
    else $error("standby pin ignored");

  sequence s_rmw_read;
    mem_rd_req && mem_ack && !is_move && dp_ff == CPUSM_DP_READ;
  endsequence
  property p_rmw;
    s_rmw_read ##1 (mem_wr_req && !st_reset && !st_hwstby) |->
      mem_wdata == bit_modify(kind_ff, $past(mem_rdata), bit_ff, carry_ff)
      && mem_addr == src_ff;
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("bit op wrote wrong byte");

  property p_move_zero;
    (op_take && move_req && op_count == '0) |=> op_done && dp_idle;
  endproperty
  a_move_zero: assert property (p_move_zero)
    else $error("empty block move not finished at once");

endmodule : cpusm_ctrl

// ### tb/cpusm_mem_model.sv
/* cpusm_mem_model: byte memory and vector source facing cpusm_ctrl.
   Assumes requests are held until the one-cycle ack. */
`timescale 1ns/10ps
module cpusm_mem_model #(
  parameter logic [23:0] VEC = 24'h000100  // start address served
) (
  input  wire logic        clock,                // system clock
  input  wire logic        mem_rd_req,           // byte read request
  input  wire logic        mem_wr_req,           // byte write request
  input  wire logic [23:0] mem_addr,             // byte address
  input  wire logic [7:0]  mem_wdata,            // write byte
  output logic             mem_ack = 1'b0,       // access done
  output logic [7:0]       mem_rdata = 8'h00,    // read byte
  input  wire logic        vec_rd_req,           // vector request
  output logic             vec_rd_ack = 1'b0,    // vector done
  output logic [23:0]      vec_rd_data = 24'h0   // start address
);
  logic [7:0] mem [256];  // only the low address byte decodes

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i);
  end

  // one-cycle acks; data inverted outside the ack so stale is not seen
  always @(posedge clock) begin
    mem_ack <= (mem_rd_req | mem_wr_req) & ~mem_ack;
    vec_rd_ack <= vec_rd_req & ~vec_rd_ack;
    mem_rdata <= (mem_rd_req & ~mem_ack) ? mem[mem_addr[7:0]] : ~mem_rdata;
    vec_rd_data <= (vec_rd_req & ~vec_rd_ack) ? VEC : ~vec_rd_data;
    if (mem_wr_req & mem_ack) mem[mem_addr[7:0]] <= mem_wdata;
  end
endmodule : cpusm_mem_model

// ### tb/testbench.sv
/* testbench: drives cpusm_ctrl with a memory model on its far side.
   Assumes the design files are compiled first. */
`timescale 1ns/10ps
module testbench;
  import cpusm_pkg::*;
  logic clock, sys_rst, chip_reset_in_n, standby_in_n, wdt_ovf, bus_req;
  logic mode_sel_pin_hi, mode_sel_pin_mid, mode_sel_pin_lo, exc_req;
  logic sleep_exec, instr_done, op_start, op_carry, mode_status_rd;
  logic bus_grant, exc_ack, vec_rd_req, vec_rd_ack, exec_step, op_ready;
  logic op_done, op_range_err, mem_rd_req, mem_wr_req, mem_ack, rom_en;
  logic periph_rst, irq_mask, adv_addr, emul_mode, ext_bus, mode_invalid;
  logic [23:0] exc_vec_addr, vec_rd_addr, vec_rd_data, pc, op_addr;
  logic [23:0] op_dst, mem_addr;
  logic [15:0] op_count;
  logic [7:0]  mem_wdata, mem_rdata;
  logic [5:0]  cpu_state;
  logic [2:0]  instr_len, op_kind, op_bit, mode_num, mode_pin_status;
  int n_mismatch = 0;
  int check_count = 0;
  // {pins, mode, rom, invalid, advanced, emulation, ext bus} per pattern
  logic [10:0] rows [8] = '{11'h008, 11'h125, 11'h254, 11'h370,
                            11'h408, 11'h508, 11'h6D2, 11'h7F2};
  logic [2:0] bits [5] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h5};
  logic [7:0] bexp [5] = '{8'h21, 8'h20, 8'h20, 8'h27, 8'h04};

  cpusm_ctrl dut_u (.*);
  cpusm_mem_model mm_u (.*);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic wait_st(input logic [5:0] s);
    for (int i = 0; i < 80 && cpu_state !== s; i++) tick(1);
  endtask : wait_st

  // reset pulse with new mode pins, back to execution
  task automatic pin_rst(input logic [2:0] p);
    @(posedge clock);
    {mode_sel_pin_hi, mode_sel_pin_mid, mode_sel_pin_lo} <= p;
    chip_reset_in_n <= 1'b0;
    tick(6);
    chk(cpu_state, CPUSM_ST_RESET);
    chk({irq_mask, periph_rst}, 2'h3);
    @(posedge clock) chip_reset_in_n <= 1'b1;
    wait_st(CPUSM_ST_EXEC);
    chk(pc, 24'h000100);
  endtask : pin_rst

  task automatic op(input logic [2:0] k, input logic [23:0] a,
                    input logic [23:0] d, input logic [15:0] n);
    @(posedge clock);
    {op_kind, op_addr, op_dst, op_count} <= {k, a, d, n};
    op_start <= 1'b1;
    @(posedge clock) op_start <= 1'b0;
    #1;
    for (int i = 0; i < 80 && op_done !== 1'b1; i++) tick(1);
  endtask : op

  task automatic close_out;
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // hang guard, over a hundred times the expected run
  initial begin
    #5_000_000;
    n_mismatch++;
    close_out();
  end

  initial begin
    {wdt_ovf, bus_req, exc_req, sleep_exec, instr_done, op_start} = '0;
    {mode_status_rd, exc_vec_addr, instr_len, op_kind, op_addr} = '0;
    {op_dst, op_count, op_bit, mode_sel_pin_hi} = '0;
    {mode_sel_pin_mid, mode_sel_pin_lo, op_carry} = 3'h7;
    {sys_rst, chip_reset_in_n, standby_in_n} = 3'h7;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    wait_st(CPUSM_ST_EXEC);
    foreach (rows[i]) begin
      pin_rst(rows[i][10:8]);
      chk(mode_num, rows[i][7:5]);
      chk({rom_en, mode_invalid}, rows[i][4:3]);
      chk({adv_addr, emul_mode, ext_bus}, rows[i][2:0]);
    end
    @(posedge clock);
    {mode_sel_pin_hi, mode_sel_pin_mid, mode_sel_pin_lo} <= 3'h2;
    tick(4);
    chk(mode_num, 3'h7);
    @(posedge clock) mode_status_rd <= 1'b1;
    @(posedge clock) mode_status_rd <= 1'b0;
    #1 chk(mode_pin_status, 3'h2);
    for (int k = 0; k < 5; k++) begin
      @(posedge clock) op_bit <= bits[k];
      op(3'(k), 24'h20 + 24'(k), 24'h0, 16'h0);
      chk(mm_u.mem[8'h20 + 8'(k)], bexp[k]);
    end
    op(3'h5, 24'h10, 24'h40, 16'h4);
    for (int i = 0; i < 4; i++) chk(mm_u.mem[8'h40 + i], 8'h10 + i);
    op(3'h5, 24'h10, 24'h80, 16'h0);
    chk({op_done, mem_rd_req, mm_u.mem[8'h80]}, 10'h280);
    op(3'h5, 24'h0, 24'hFFFFFF, 16'h2);
    chk(op_range_err, 1'b1);
    @(posedge clock) bus_req <= 1'b1;
    tick(4);
    chk({bus_grant, op_ready, cpu_state}, {2'h2, CPUSM_ST_BUSREL});
    @(posedge clock) bus_req <= 1'b0;
    wait_st(CPUSM_ST_EXEC);
    @(posedge clock) wdt_ovf <= 1'b1;
    @(posedge clock) wdt_ovf <= 1'b0;
    #1 chk(cpu_state, CPUSM_ST_RESET);
    wait_st(CPUSM_ST_EXEC);
    @(posedge clock) sleep_exec <= 1'b1;
    @(posedge clock) sleep_exec <= 1'b0;
    tick(1);
    chk(cpu_state, CPUSM_ST_STOP);
    @(posedge clock) {exc_req, exc_vec_addr} <= {1'b1, 24'h000040};
    #1 chk(exc_ack, 1'b1);
    wait_st(CPUSM_ST_EXCEPT);
    chk(vec_rd_addr, 24'h000040);
    @(posedge clock) exc_req <= 1'b0;
    wait_st(CPUSM_ST_EXEC);
    chk(pc, 24'h000100);
    chk(exec_step, 1'b1);
    @(posedge clock) {instr_done, instr_len} <= 4'hB;
    @(posedge clock) instr_done <= 1'b0;
    #1 chk(pc, 24'h000103);
    @(posedge clock) standby_in_n <= 1'b0;
    tick(4);
    chk(cpu_state, CPUSM_ST_HWSTBY);
    close_out();
  end
endmodule : testbench
